/* File: flash_table_access.sv */
// Table pointer, table latch, holding registers and long-operation timer
// for self-programming of on-chip program flash.
// Assumes the core stalls while O_STALL is high, issues at most one table
// operation every two cycles, and the flash array answers a read in the same
// cycle as the request, with the addressed 16-bit word.
`timescale 1ns/10ps

// Behaviour
// - Pointer joins upper, high, low into 22 bits
// - Top pointer bit selects ID/configuration space
// - Four pointer updates: keep, post-inc, post-dec, pre-inc
// - Auto updates touch only lower 21 bits
// - Table read addresses with all 22 bits
// - Table write fills holding register by bits 2:0
// - Program block chosen by bits 21:3
// - Row erase chosen by bits 21:6
// - Address lsb picks low or high byte
// - One byte per table read into latch
// - Smallest firmware erase is 64-byte row
// - Row erase ignores the table latch
// - Unlock 55h then AAh before go
// - Core stalls until internal timer ends operation
// - Programming always writes whole 8-byte block
// - Table writes only load holding registers
// - Go bit refused while write enable clear
// - Write go bit software-set, hardware-cleared at completion; read go bit always reads zero
// - Reset mid-operation flags error, keeps selects
// - Completion sets done flag, software clears it
module flash_table_access #(
    parameter int LONG_CYCLES = flash_table_pkg::LONG_OP_CYCLES
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RSTN,
    input wire logic I_PORN,
    input wire logic I_CE,
    input wire logic I_REG_WE,
    input wire flash_table_pkg::reg_sel_t I_REG_SEL,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_TBL_RD,
    input wire logic I_TBL_WR,
    input wire flash_table_pkg::ptr_mode_t I_TBL_MODE,
    input wire logic [15:0] I_FL_RDATA,
    input wire logic I_DONE_CLR,
    output logic [flash_table_pkg::PTR_W-1:0] O_PTR,
    output logic [7:0] O_LATCH,
    output flash_table_pkg::ctrl_t O_CTRL,
    output logic O_STALL,
    output logic O_DONE_FLAG,
    output flash_table_pkg::flash_req_t O_FL_REQ,
    output logic [8*flash_table_pkg::HOLD_N-1:0] O_FL_WDATA
);
    import flash_table_pkg::*;

    localparam logic [TIMER_W-1:0] LAST_TICK = TIMER_W'(LONG_CYCLES - 1);

    logic [PTR_W-1:0] ptr_ff;
    logic [7:0] latch_ff;
    ctrl_t ctrl_ff;
    op_state_t op_ff;
    logic [TIMER_W-1:0] timer_ff;
    logic [1:0] key_stage_ff;
    logic done_ff;
    flash_req_t req_ff;
    logic rd_lsb_ff;
    logic stall_ff;

    // ==========================================================
    // Pointer arithmetic
    // Wrap stays inside the low field so the space select never flips
    wire [LOW_W-1:0] low_inc = ptr_ff[LOW_W-1:0] + 21'h000001;
    wire [LOW_W-1:0] low_dec = ptr_ff[LOW_W-1:0] - 21'h000001;
    wire busy = (op_ff != OP_IDLE);
    wire tbl_go = (I_TBL_RD || I_TBL_WR) && !busy;
    wire reg_wr = I_REG_WE && !busy;
    wire [PTR_W-1:0] access_addr = (I_TBL_MODE == PTR_PRE_INC) ?
        {ptr_ff[PTR_W-1], low_inc} : ptr_ff;
    wire [PTR_W-1:0] ptr_after =
        (I_TBL_MODE == PTR_POST_INC || I_TBL_MODE == PTR_PRE_INC) ?
        {ptr_ff[PTR_W-1], low_inc} :
        (I_TBL_MODE == PTR_POST_DEC) ? {ptr_ff[PTR_W-1], low_dec} : ptr_ff;

    // Register write pointer byte loads
    wire [PTR_W-1:0] ptr_loaded =
        (I_REG_SEL == SEL_PTR_UPPER) ? {I_REG_WDATA[5:0], ptr_ff[15:0]} :
        (I_REG_SEL == SEL_PTR_HIGH) ? {ptr_ff[21:16], I_REG_WDATA, ptr_ff[7:0]} :
        (I_REG_SEL == SEL_PTR_LOW) ? {ptr_ff[21:8], I_REG_WDATA} : ptr_ff;
    wire [PTR_W-1:0] nxt_ptr = tbl_go ? ptr_after : reg_wr ? ptr_loaded : ptr_ff;

    // ==========================================================
    // Unlock sequence and start decode
    // Any register write other than the keys disarms, so stray code cannot start
    wire key_first = reg_wr && I_REG_SEL == SEL_UNLOCK_KEY && I_REG_WDATA == KEY_FIRST;
    wire key_second = reg_wr && I_REG_SEL == SEL_UNLOCK_KEY && I_REG_WDATA == KEY_SECOND;
    wire [1:0] nxt_key_stage = !reg_wr ? key_stage_ff :
        key_first ? 2'h1 : (key_second && key_stage_ff == 2'h1) ? 2'h2 : 2'h0;
    ctrl_t wr_ctrl;
    assign wr_ctrl = ctrl_t'(I_REG_WDATA);
    wire ctrl_wr = reg_wr && I_REG_SEL == SEL_CONTROL;
    // Data EEPROM path is absent, so only program or configuration space starts
    wire start = ctrl_wr && wr_ctrl.write_go && key_stage_ff == 2'h2
        && wr_ctrl.write_enable_bit
        && (wr_ctrl.program_memory_select || wr_ctrl.config_space_select);
    wire finish = busy && timer_ff == LAST_TICK;

    // Program block and erase row addresses with ignored bits cleared
    wire [PTR_W-1:0] block_addr = {ptr_ff[PTR_W-1:HOLD_SEL_W], 3'h0};
    wire [PTR_W-1:0] row_addr = {ptr_ff[PTR_W-1:ROW_SEL_W], 6'h00};

    // Control register next value
    ctrl_t nxt_ctrl;
    assign nxt_ctrl.program_memory_select = ctrl_wr ? wr_ctrl.program_memory_select :
        ctrl_ff.program_memory_select;
    assign nxt_ctrl.config_space_select = ctrl_wr ? wr_ctrl.config_space_select :
        ctrl_ff.config_space_select;
    assign nxt_ctrl.unused_zero = 1'b0;
    assign nxt_ctrl.row_erase = finish ? 1'b0 : ctrl_wr ? wr_ctrl.row_erase :
        ctrl_ff.row_erase;
    assign nxt_ctrl.write_error_flag = ctrl_wr ? wr_ctrl.write_error_flag :
        ctrl_ff.write_error_flag;
    assign nxt_ctrl.write_enable_bit = ctrl_wr ? wr_ctrl.write_enable_bit :
        ctrl_ff.write_enable_bit;
    assign nxt_ctrl.write_go = finish ? 1'b0 : start ? 1'b1 : ctrl_ff.write_go;
    assign nxt_ctrl.read_go = 1'b0;

    // Flash request: one-cycle strobes, address held until the next request
    flash_req_t nxt_req;
    assign nxt_req.rd = tbl_go && I_TBL_RD;
    assign nxt_req.prog = start && !wr_ctrl.row_erase;
    assign nxt_req.erase = start && wr_ctrl.row_erase;
    assign nxt_req.addr = (tbl_go && I_TBL_RD) ? access_addr :
        !start ? req_ff.addr : wr_ctrl.row_erase ? row_addr : block_addr;

    wire [7:0] read_byte = rd_lsb_ff ? I_FL_RDATA[15:8] : I_FL_RDATA[7:0];
    wire [7:0] nxt_latch = req_ff.rd ? read_byte :
        (reg_wr && I_REG_SEL == SEL_LATCH) ? I_REG_WDATA : latch_ff;
    wire [TIMER_W-1:0] nxt_timer = busy ? timer_ff + 20'h00001 : 20'h00000;

    // ==========================================================
    // Operation state
    op_state_t nxt_op;
    always_comb begin
        nxt_op = op_ff;
        case (op_ff)
            OP_IDLE: begin
                if (start) begin
                    nxt_op = wr_ctrl.row_erase ? OP_ERASE : OP_PROGRAM;
                end
            end
            OP_PROGRAM, OP_ERASE: begin
                if (finish) begin
                    nxt_op = OP_IDLE;
                end
            end
            default: nxt_op = OP_IDLE;
        endcase
    end

    // Control register; device reset keeps selects and records an abort
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_PORN) begin
            ctrl_ff <= ctrl_t'(BYTE_RST);
        end else if (!I_RSTN) begin
            ctrl_ff.write_error_flag <= ctrl_ff.write_error_flag | busy;
            ctrl_ff.unused_zero <= 1'b0;
            ctrl_ff.row_erase <= 1'b0;
            ctrl_ff.write_enable_bit <= 1'b0;
            ctrl_ff.write_go <= 1'b0;
            ctrl_ff.read_go <= 1'b0;
        end else if (I_CE) begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Remaining state
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN || !I_PORN) begin
            ptr_ff <= PTR_RST;
            latch_ff <= BYTE_RST;
            op_ff <= OP_IDLE;
            timer_ff <= '0;
            key_stage_ff <= 2'h0;
            done_ff <= 1'b0;
            req_ff <= '0;
            rd_lsb_ff <= 1'b0;
            stall_ff <= 1'b0;
        end else if (I_CE) begin
            ptr_ff <= nxt_ptr;
            latch_ff <= nxt_latch;
            op_ff <= nxt_op;
            timer_ff <= nxt_timer;
            key_stage_ff <= nxt_key_stage;
            done_ff <= finish | (done_ff & !I_DONE_CLR);
            req_ff <= nxt_req;
            rd_lsb_ff <= access_addr[0];
            stall_ff <= (nxt_op != OP_IDLE);
        end
    end

    // ==========================================================
    // Holding registers, one byte each
    logic [7:0] hold_ff [HOLD_N];
    genvar gi;
    generate
        for (gi = 0; gi < HOLD_N; gi++) begin : g_hold
            wire hit = tbl_go && I_TBL_WR && access_addr[2:0] == HOLD_SEL_W'(gi);
            always_ff @(posedge I_CLK_SYS) begin
                if (!I_RSTN || !I_PORN) begin
                    hold_ff[gi] <= BYTE_RST;
                end else if (I_CE && hit) begin
                    hold_ff[gi] <= latch_ff;
                end
            end
            assign O_FL_WDATA[8*gi +: 8] = hold_ff[gi];
        end
    endgenerate

    // Outputs are plain register copies, so the core never sees decode glitches
    assign O_PTR = ptr_ff;
    assign O_LATCH = latch_ff;
    assign O_CTRL = ctrl_ff;
    assign O_STALL = stall_ff;
    assign O_DONE_FLAG = done_ff;
    assign O_FL_REQ = req_ff;

    // ==========================================================
    // Assertions
    a_top_bit_kept: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (tbl_go && I_CE && !I_REG_WE) |=> O_PTR[21] == $past(O_PTR[21]))
        else $error("Table op changed pointer top bit");
    a_post_dec: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (tbl_go && I_CE && I_TBL_MODE == PTR_POST_DEC)
        |=> O_PTR[20:0] == $past(O_PTR[20:0]) - 21'h000001)
        else $error("Post-decrement wrong");
    a_read_addr: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (tbl_go && I_CE && I_TBL_RD && I_TBL_MODE == PTR_KEEP)
        |=> O_FL_REQ.rd && O_FL_REQ.addr == $past(O_PTR))
        else $error("Read address not the pointer");
    a_byte_pick: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (O_FL_REQ.rd && I_CE && O_FL_REQ.addr[0])
        |=> O_LATCH == $past(I_FL_RDATA[15:8]))
        else $error("Odd address did not give high byte");
    a_hold_fill: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (tbl_go && I_CE && I_TBL_WR && I_TBL_MODE != PTR_PRE_INC)
        |=> O_FL_WDATA[8*$past(O_PTR[2:0]) +: 8] == $past(O_LATCH))
        else $error("Holding register not loaded");
    a_start_keyed: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        $rose(O_STALL) |-> $past(key_stage_ff) == 2'h2 && $past(I_REG_WDATA[2]))
        else $error("Long op started without unlock or enable");
    a_stall_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        $rose(O_STALL) |-> O_STALL[*8])
        else $error("Stall dropped early");
    a_block_align: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_FL_REQ.prog |-> O_FL_REQ.addr[2:0] == 3'h0)
        else $error("Program address not block aligned");
    a_row_align: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_FL_REQ.erase |-> O_FL_REQ.addr[5:0] == 6'h00)
        else $error("Erase address not row aligned");
    a_finish_flags: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        ($fell(O_STALL) && $past(I_RSTN))
        |-> O_DONE_FLAG && !O_CTRL.write_go && !O_CTRL.row_erase)
        else $error("Completion did not update flags");
    c_erase: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) O_FL_REQ.erase);
    c_program: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) O_FL_REQ.prog);
    c_read: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) O_FL_REQ.rd);
    c_done: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN) $fell(O_STALL));
    c_abort: cover property (@(posedge I_CLK_SYS) !I_RSTN && O_STALL);

    // ==========================================================
    // Refusal, reset and timing checks
    // Helper count of stall cycles, kept apart from the design timer
    logic [TIMER_W-1:0] stall_len_ff;
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RSTN || !I_PORN || !O_STALL) begin
            stall_len_ff <= '0;
        end else if (I_CE) begin
            stall_len_ff <= stall_len_ff + 20'h00001;
        end
    end
    a_stall_len: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        ($fell(O_STALL) && $past(I_RSTN)) |-> stall_len_ff == TIMER_W'(LONG_CYCLES))
        else $error("Long operation length wrong");
    a_busy_no_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_STALL |=> !O_FL_REQ.rd)
        else $error("Table read served during stall");
    a_write_enable_bit_gate: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (I_REG_WE && I_CE && !O_STALL && !I_REG_WDATA[2]) |=> !O_STALL)
        else $error("Long op started without write enable");
    a_abort_error: assert property (@(posedge I_CLK_SYS) disable iff (!I_PORN)
        (!I_RSTN && O_STALL) |=> O_CTRL.write_error_flag
        && O_CTRL.program_memory_select == $past(O_CTRL.program_memory_select))
        else $error("Aborted operation not flagged");
    a_upper_load: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (I_REG_WE && I_CE && !O_STALL && !I_TBL_RD && !I_TBL_WR
        && I_REG_SEL == SEL_PTR_UPPER) |=> O_PTR[21:16] == $past(I_REG_WDATA[5:0]))
        else $error("Upper pointer byte not loaded");
    a_done_sticky: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (O_DONE_FLAG && !I_DONE_CLR && I_CE) |=> O_DONE_FLAG)
        else $error("Done flag dropped without clear");
    a_short_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (tbl_go && I_CE && I_TBL_WR) |=> !O_FL_REQ.prog && !O_STALL)
        else $error("Table write started a long write");
    a_pre_inc_addr: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        (tbl_go && I_CE && I_TBL_RD && I_TBL_MODE == PTR_PRE_INC)
        |=> O_FL_REQ.addr == O_PTR)
        else $error("Pre-increment read used old pointer");
    a_erase_row: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
        O_FL_REQ.erase |-> O_STALL && O_CTRL.row_erase)
        else $error("Erase request without row erase stall");
endmodule

/* File: flash_table_pkg.sv */
// Constants, types and carriers for the program flash table access block.
// Assumes one core clock at 250 MHz shared by the core and this block.
package flash_table_pkg;

    // ==========================================================
    // Pointer geometry
    localparam int PTR_W = 22;
    localparam int LOW_W = 21;
    localparam int HOLD_N = 8;
    localparam int HOLD_SEL_W = 3;
    localparam int ROW_SEL_W = 6;

    // ==========================================================
    // Unlock key values
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // ==========================================================
    // Long operation timing
    localparam int CLK_MHZ = 250;
    localparam int LONG_OP_US = 2000;
    localparam int LONG_OP_CYCLES = LONG_OP_US * CLK_MHZ;
    localparam int TIMER_W = 20;

    // ==========================================================
    // Reset values
    localparam logic [PTR_W-1:0] PTR_RST = 22'h000000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Pointer update applied by a table read or write
    typedef enum logic [1:0] {
        PTR_KEEP,
        PTR_POST_INC,
        PTR_POST_DEC,
        PTR_PRE_INC
    } ptr_mode_t;

    // Register addressed by a core register write
    typedef enum logic [2:0] {
        SEL_PTR_UPPER,
        SEL_PTR_HIGH,
        SEL_PTR_LOW,
        SEL_LATCH,
        SEL_CONTROL,
        SEL_UNLOCK_KEY
    } reg_sel_t;

    // Long operation in progress
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_PROGRAM,
        OP_ERASE
    } op_state_t;

    // Memory control register, bit 7 down to bit 0
    typedef struct packed {
        logic program_memory_select;
        logic config_space_select;
        logic unused_zero;
        logic row_erase;
        logic write_error_flag;
        logic write_enable_bit;
        logic write_go;
        logic read_go;
    } ctrl_t;

    // Request toward the flash array
    typedef struct packed {
        logic rd;
        logic prog;
        logic erase;
        logic [PTR_W-1:0] addr;
    } flash_req_t;

endpackage

/* File: flash_array_model.sv */
// Behavioural program flash array that answers table reads with a word
// derived from the address. Assumes the word is wanted during the read
// strobe and in the cycle after it.
`timescale 1ns/10ps
module flash_array_model
    import flash_table_pkg::*;
(
    input wire logic i_clk,
    input wire flash_table_pkg::flash_req_t i_req,
    output logic [15:0] o_rdata
);
    logic rd_d_ff = 1'b0;
    logic [7:0] base;
    logic [15:0] word;
    // ==========================================================
    // Word contents
    // Top address bit enters the data, so config space reads look different
    assign base = {i_req.addr[21], i_req.addr[7:1]};
    assign word = {base ^ 8'hA5, base};
    // Outside the valid window show the inverse, never a stale copy
    assign o_rdata = (i_req.rd || rd_d_ff) ? word : ~word;
    always_ff @(posedge i_clk) begin
        rd_d_ff <= i_req.rd;
    end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the flash table access block.
// Assumes a flash model answering reads; long operations shortened to 20.
`timescale 1ns/10ps
module tb_top;
    import flash_table_pkg::*;
    localparam int LC = 20;
    typedef struct packed {ptr_mode_t m; logic [21:0] p, np, a;} row_t;
    logic I_CLK_SYS = 0, I_RSTN = 0, I_PORN = 0, I_REG_WE = 0;
    logic I_TBL_RD = 0, I_TBL_WR = 0, I_DONE_CLR = 0, I_CE = 1;
    reg_sel_t I_REG_SEL = SEL_PTR_LOW;
    logic [7:0] I_REG_WDATA = 8'h00;
    ptr_mode_t I_TBL_MODE = PTR_KEEP;
    logic [15:0] I_FL_RDATA;
    logic [21:0] O_PTR;
    logic [7:0] O_LATCH;
    ctrl_t O_CTRL;
    logic O_STALL, O_DONE_FLAG;
    flash_req_t O_FL_REQ;
    logic [63:0] O_FL_WDATA, hold;
    int mismatches = 0, checks = 0, n;
    row_t rows [6] = '{
        '{PTR_KEEP, 22'h000123, 22'h000123, 22'h000123},
        '{PTR_POST_INC, 22'h000124, 22'h000125, 22'h000124},
        '{PTR_POST_DEC, 22'h000000, 22'h1FFFFF, 22'h000000},
        '{PTR_PRE_INC, 22'h1FFFFF, 22'h000000, 22'h000000},
        '{PTR_POST_INC, 22'h3FFFFF, 22'h200000, 22'h3FFFFF},
        '{PTR_PRE_INC, 22'h200010, 22'h200011, 22'h200011}};
    flash_table_access #(.LONG_CYCLES(LC)) dut_u (.I_CLK_SYS(I_CLK_SYS),
        .I_RSTN(I_RSTN), .I_PORN(I_PORN), .I_CE(I_CE), .I_REG_WE(I_REG_WE),
        .I_REG_SEL(I_REG_SEL), .I_REG_WDATA(I_REG_WDATA), .I_TBL_RD(I_TBL_RD),
        .I_TBL_WR(I_TBL_WR), .I_TBL_MODE(I_TBL_MODE), .I_FL_RDATA(I_FL_RDATA),
        .I_DONE_CLR(I_DONE_CLR), .O_PTR(O_PTR), .O_LATCH(O_LATCH),
        .O_CTRL(O_CTRL), .O_STALL(O_STALL), .O_DONE_FLAG(O_DONE_FLAG),
        .O_FL_REQ(O_FL_REQ), .O_FL_WDATA(O_FL_WDATA));
    flash_array_model flash_u (.i_clk(I_CLK_SYS), .i_req(O_FL_REQ),
        .o_rdata(I_FL_RDATA));
    // ==========================================================
    // Clock and helpers
    initial begin
        forever #2 I_CLK_SYS = ~I_CLK_SYS;
    end
    task automatic summarize;
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [21:0] a);
        logic [7:0] b;
        b = {a[21], a[7:1]};
        return a[0] ? b ^ 8'hA5 : b;
    endfunction
    // Each write leaves a gap cycle so the strobe is never reassigned at once
    task automatic regw(input reg_sel_t s, input logic [7:0] d);
        I_REG_SEL = s;
        I_REG_WDATA = d;
        I_REG_WE = 1;
        @(negedge I_CLK_SYS);
        I_REG_WE = 0;
        @(negedge I_CLK_SYS);
    endtask
    task automatic setp(input logic [21:0] p);
        regw(SEL_PTR_UPPER, {2'b00, p[21:16]});
        regw(SEL_PTR_HIGH, p[15:8]);
        regw(SEL_PTR_LOW, p[7:0]);
    endtask
    task automatic tbl(input logic wr, input ptr_mode_t m);
        I_TBL_MODE = m;
        I_TBL_RD = !wr;
        I_TBL_WR = wr;
        @(negedge I_CLK_SYS);
        I_TBL_RD = 0;
        I_TBL_WR = 0;
    endtask
    // Full unlock sequence; returns in the cycle after the go write is taken, with stall already high
    task automatic start(input logic [7:0] c);
        regw(SEL_CONTROL, c & 8'hFD);
        regw(SEL_UNLOCK_KEY, KEY_FIRST);
        regw(SEL_UNLOCK_KEY, KEY_SECOND);
        I_REG_SEL = SEL_CONTROL;
        I_REG_WDATA = c;
        I_REG_WE = 1;
        @(negedge I_CLK_SYS);
        I_REG_WE = 0;
    endtask
    task automatic wait_done;
        n = 0;
        while (O_STALL === 1'b1 && n < 100) begin
            @(negedge I_CLK_SYS);
            n++;
        end
        if (n >= 100) begin
            mismatches++;
            summarize();
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(negedge I_CLK_SYS);
        I_RSTN = 1;
        I_PORN = 1;
        @(negedge I_CLK_SYS);
        chk({O_PTR, O_LATCH, O_CTRL, O_STALL, O_DONE_FLAG}, 0);
        chk(O_FL_WDATA, 0);
        foreach (rows[k]) begin
            setp(rows[k].p);
            tbl(1'b0, rows[k].m);
            chk(O_FL_REQ.rd, 1);
            chk(O_FL_REQ.addr, rows[k].a);
            chk(O_PTR, rows[k].np);
            @(negedge I_CLK_SYS);
            chk(O_FL_REQ.rd, 0);
            chk(O_LATCH, exp_byte(rows[k].a));
        end
        // Eight short writes starting mid-block wrap round the holding set
        setp(22'h000105);
        hold = 0;
        for (int i = 0; i < 8; i++) begin
            regw(SEL_LATCH, 8'hC0 + 8'(i));
            tbl(1'b1, PTR_POST_INC);
            hold[8*((5+i)%8) +: 8] = 8'hC0 + 8'(i);
        end
        @(negedge I_CLK_SYS);
        chk(O_FL_WDATA, hold);
        chk(O_FL_REQ.prog, 0);
        start(8'h86);
        chk({O_STALL, O_CTRL.write_go, O_FL_REQ.prog, O_FL_REQ.erase}, 4'hE);
        chk(O_FL_REQ.addr[21:3], 19'(22'h00010D >> 3));
        tbl(1'b0, PTR_POST_INC);
        chk(O_PTR, 22'h00010D);
        wait_done();
        chk(n >= LC - 2 && n <= LC + 1, 1);
        chk({O_CTRL.write_go, O_DONE_FLAG}, 2'h1);
        @(negedge I_CLK_SYS);
        I_DONE_CLR = 1;
        @(negedge I_CLK_SYS);
        I_DONE_CLR = 0;
        @(negedge I_CLK_SYS);
        chk(O_DONE_FLAG, 0);
        // Row erase from an unaligned pointer, latch left holding data
        setp(22'h0002FF);
        start(8'h96);
        chk({O_STALL, O_FL_REQ.erase, O_FL_REQ.prog}, 3'h6);
        chk(O_FL_REQ.addr[21:6], 16'(22'h0002FF >> 6));
        wait_done();
        chk({O_CTRL.row_erase, O_CTRL.write_go, O_DONE_FLAG}, 3'h1);
        // Go attempts that must be refused
        regw(SEL_CONTROL, 8'h86);
        chk(O_STALL, 0);
        regw(SEL_UNLOCK_KEY, KEY_SECOND);
        regw(SEL_UNLOCK_KEY, KEY_FIRST);
        regw(SEL_CONTROL, 8'h86);
        chk(O_STALL, 0);
        regw(SEL_UNLOCK_KEY, KEY_FIRST);
        regw(SEL_PTR_LOW, 8'h00);
        regw(SEL_UNLOCK_KEY, KEY_SECOND);
        regw(SEL_CONTROL, 8'h86);
        chk(O_STALL, 0);
        start(8'h82);
        @(negedge I_CLK_SYS);
        chk({O_STALL, O_CTRL.write_go}, 0);
        regw(SEL_CONTROL, 8'h81);
        chk(O_CTRL.read_go, 0);
        // Reset in the middle of an erase
        start(8'h96);
        @(negedge I_CLK_SYS);
        I_RSTN = 0;
        @(negedge I_CLK_SYS);
        I_RSTN = 1;
        @(negedge I_CLK_SYS);
        chk({O_CTRL.write_error_flag, O_CTRL.program_memory_select}, 2'h3);
        chk({O_STALL, O_CTRL.write_go}, 0);
        // Clock enable low freezes the pointer and the read strobe
        I_CE = 0;
        tbl(1'b0, PTR_POST_INC);
        chk({O_PTR, O_FL_REQ.rd}, 0);
        I_CE = 1;
        summarize();
    end
endmodule
